// file: src/sram_ctl_pkg.sv
/*
  Constants for the asynchronous 1M x 16 static memory controller.
  Assumes a 50 MHz system clock; all times are turned into cycle counts here.
*/
package sram_ctl_pkg;
  localparam int          CLK_PERIOD_NS      = 20;
  localparam int          ADDR_W             = 20;
  localparam int          DATA_W             = 16;
  localparam int          LANES              = 2;
  // Power-on settle interval before first access
  localparam int          POWER_SETTLE_MS    = 1;
  localparam int          POWER_SETTLE_CYC   = POWER_SETTLE_MS * 1000000 / CLK_PERIOD_NS;
  // Write timing: write float delay plus data setup to write end (slowest grade)
  localparam int          WRITE_FLOAT_NS     = 6;
  localparam int          DATA_SETUP_NS      = 6;
  localparam int          WRITE_PULSE_NS     = 8;
  localparam int          WR_PULSE_NS_TOTAL  = (WRITE_FLOAT_NS + DATA_SETUP_NS > WRITE_PULSE_NS) ?
                                               WRITE_FLOAT_NS + DATA_SETUP_NS : WRITE_PULSE_NS;
  localparam int          WR_PULSE_CYC       = (WR_PULSE_NS_TOTAL + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Read access time, rounded up
  localparam int          ACCESS_NS          = 12;
  localparam int          RD_WAIT_CYC        = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Bus turnaround after releasing the data pins
  localparam int          FLOAT_NS           = 6;
  localparam int          TURN_CYC           = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W              = 16;
  localparam logic [3:0]  CNT_ONE            = 4'h1;
endpackage : sram_ctl_pkg

// file: src/sram_wait_if.sv
/*
  Carrier between the controller and its wait counter.
  Assumes one clock domain.
*/
`timescale 1ns/10ps
interface sram_wait_if;
  logic        load;
  logic [15:0] count;
  logic        done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface : sram_wait_if

// file: src/sram_wait_timer.sv
/*
  Down counter used for the read, write and turnaround phases of the controller; power settle has its own counter.
  Load is high on every state change of the controller, so it can stay high several cycles; done is high while the count is zero.
*/
`timescale 1ns/10ps
module sram_wait_timer (
  input  wire logic  i_mclk,
  input  wire logic  i_rst_n,
  sram_wait_if.tmr   tmr
);
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;

  // Load or count down to zero
  assign nxt_cnt  = tmr.load ? tmr.count : ((cnt_ff != 16'h0) ? cnt_ff - 16'h1 : cnt_ff);
  assign tmr.done = (cnt_ff == 16'h0);   // Not gated by load: load is decoded from done

  // Counter register
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) cnt_ff <= 16'h0;
    else          cnt_ff <= nxt_cnt;
  end
endmodule : sram_wait_timer

// file: src/sram_ctl.sv
/*
  Host controller for an asynchronous 1M x 16 static memory with byte lanes.
  One request is taken at a time from the user port. A write opens the selects,
  lanes and strobe on one edge, lifts the strobe a cycle later and drops the
  selects after that. A read holds the selects and output enable for two
  cycles and captures the data on the last one. Every access ends in a
  turnaround cycle. Write data is driven only while the strobe is low and one
  cycle after.
  Assumes the user request port is synchronous to i_mclk and that the bench
  resolves the shared data wire from o_dq_oe.
  Assumes the supply is already at its operating level when reset is released,
  so the settle count starts from reset.
*/
`timescale 1ns/10ps
// How it works
// R01 - After reset wait the power settle interval before any access.
// R02 - Memory writes only while selected and write strobe is low.
// R03 - Write opens with selects, strobe and a lane enable active; ending one closes it.
// R04 - Memory drives read data only on enabled lanes.
// R05 - Memory captures write data only on enabled lanes; output enable ignored.
// R06 - Memory floats data when output enable or lane enables are high.
// R07 - Deselect together with strobe rise leaves the bus floating.
// R08 - Selected only when active-low select low and active-high select high.
// R09 - Write strobe pulse covers write float delay plus data setup.
// R10 - Write strobe stays high throughout every read.
// R11 - Address is valid no later than the selects become active.
// R12 - Disabled lane keeps stored contents during a write.
module sram_ctl (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_req,
  input  wire logic        i_write,
  input  wire logic [19:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic [1:0]  i_lane_en,
  output logic             o_ready,
  output logic             o_rvalid,
  output logic [15:0]      o_rdata,
  output logic [19:0]      o_sram_addr,
  output logic             o_chip_select_active_low,
  output logic             o_chip_select_active_high,
  output logic             o_out_drive_en_n,
  output logic             o_write_strobe_n,
  output logic             o_low_byte_lane_enable_n,
  output logic             o_upper_byte_lane_enable_n,
  output logic [15:0]      o_dq,
  output logic             o_dq_oe,
  input  wire logic [15:0] i_dq
);
  typedef enum logic [2:0] {
    ST_POWER = 3'b000,
    ST_IDLE  = 3'b001,
    ST_RD    = 3'b010,
    ST_WR    = 3'b011,
    ST_WEND  = 3'b100,
    ST_TURN  = 3'b101
  } state_e;

  state_e      state_ff;
  state_e      nxt_state;
  logic [19:0] addr_ff;
  logic [15:0] wdata_ff;
  logic [1:0]  lane_n_ff;
  logic        sel_ff;
  logic        oe_n_ff;
  logic        we_n_ff;
  logic        dq_oe_ff;
  logic        ready_ff;
  logic        rvalid_ff;
  logic [15:0] rdata_ff;
  logic        sel_n_ff;

  sram_wait_if wt();

  sram_wait_timer u_timer (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .tmr     (wt.tmr)
  );

  // Power settle bookkeeping; kept apart so the shared timer stays 16 bits
  logic [15:0] pwr_cnt_ff;
  wire         in_power = (state_ff == ST_POWER);
  wire         pwr_done = (pwr_cnt_ff == 16'(sram_ctl_pkg::POWER_SETTLE_CYC - 1));   // R01

  // Request accepted only in idle with at least one lane
  wire take      = (state_ff == ST_IDLE) && i_req && (i_lane_en != 2'b00);
  wire take_wr   = take && i_write;
  wire take_rd   = take && !i_write;
  wire timer_end = wt.done;

  // Next state decode
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_POWER: if (pwr_done) nxt_state = ST_IDLE;    // R01
      ST_IDLE:  if (take_wr) nxt_state = ST_WR;
                else if (take_rd) nxt_state = ST_RD;
      ST_RD:    if (timer_end) nxt_state = ST_TURN;
      ST_WR:    if (timer_end) nxt_state = ST_WEND;   // R09
      ST_WEND:  nxt_state = ST_TURN;
      ST_TURN:  if (timer_end) nxt_state = ST_IDLE;
      default:  nxt_state = ST_POWER;
    endcase
  end

  // Load value for each timed phase
  wire [15:0] rd_load   = 16'(sram_ctl_pkg::RD_WAIT_CYC);
  wire [15:0] wr_load   = 16'(sram_ctl_pkg::WR_PULSE_CYC - 1);   // R09
  wire [15:0] turn_load = 16'(sram_ctl_pkg::TURN_CYC - 1);
  wire [15:0] idle_load = 16'h0;

  // Timer loads on entry to each timed phase
  assign wt.load  = (state_ff != nxt_state) || (!i_rst_n);
  assign wt.count = (nxt_state == ST_RD)   ? rd_load :
                    (nxt_state == ST_WR)   ? wr_load :
                    (nxt_state == ST_TURN) ? turn_load : idle_load;

  // Power settle counter runs once after reset
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n)                   pwr_cnt_ff <= 16'h0;
    else if (state_ff == ST_POWER && !pwr_done) pwr_cnt_ff <= pwr_cnt_ff + 16'h1;   // R01
  end

  // State register, power phase ends on settle count
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n)                          state_ff <= ST_POWER;
    else if (state_ff == ST_POWER)         state_ff <= pwr_done ? ST_IDLE : ST_POWER;   // R01
    else                                   state_ff <= nxt_state;
  end

  // Address and data latched on take, with the selects on the same edge
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_ff  <= 20'h0;
      wdata_ff <= 16'h0;
    end else if (take) begin
      addr_ff  <= i_addr;   // R11
      wdata_ff <= i_wdata;
    end
  end

  // Lane enables follow the request and clear on the edge that ends turnaround
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n)                   lane_n_ff <= 2'h3;
    else if (take)                  lane_n_ff <= ~i_lane_en;   // R12
    else if (state_ff == ST_TURN)   lane_n_ff <= 2'h3;
  end

  // Select active only in read and write phases
  wire nxt_sel  = (nxt_state == ST_RD) || (nxt_state == ST_WR) || (nxt_state == ST_WEND);   // R08
  // Strobe low only inside the write phase, high for all reads
  wire nxt_we_n = !(nxt_state == ST_WR);   // R10
  // Output enable only during a read
  wire nxt_oe_n = !(nxt_state == ST_RD);
  // Drive data while the write strobe is low and one cycle after
  wire nxt_dq_oe = (nxt_state == ST_WR) || (nxt_state == ST_WEND);

  // Active-high select; strobe rises a cycle before the selects drop
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) sel_ff <= 1'b0;
    else          sel_ff <= !in_power && nxt_sel;   // R03
  end

  // Active-low select from its own flop, so the pin leaves a register
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) sel_n_ff <= 1'b1;
    else          sel_n_ff <= in_power || !nxt_sel;   // R08
  end

  // Write strobe low only in the write pulse
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) we_n_ff <= 1'b1;
    else          we_n_ff <= in_power || nxt_we_n;   // R02
  end

  // Output drive enable low only in the read phase
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) oe_n_ff <= 1'b1;
    else          oe_n_ff <= in_power || nxt_oe_n;   // R06
  end

  // Data drive enable for the write pulse and one cycle after
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) dq_oe_ff <= 1'b0;
    else          dq_oe_ff <= !in_power && nxt_dq_oe;   // R05
  end

  // Read data captured on the last read cycle; disabled lanes read zero
  wire        rd_last = (state_ff == ST_RD) && timer_end;
  wire [15:0] rd_mask = {{8{!lane_n_ff[1]}}, {8{!lane_n_ff[0]}}};
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n)     rdata_ff <= 16'h0;
    else if (rd_last) rdata_ff <= i_dq & rd_mask;   // R04
  end

  // Read valid is a one-cycle pulse with the captured data
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) rvalid_ff <= 1'b0;
    else          rvalid_ff <= rd_last;
  end

  // Ready only in idle, from a register; never during the settle interval
  wire nxt_ready = (nxt_state == ST_IDLE) && (!in_power || pwr_done) && !take;   // R01
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) ready_ff <= 1'b0;
    else          ready_ff <= nxt_ready;
  end

  assign o_ready                    = ready_ff;
  assign o_rvalid                   = rvalid_ff;
  assign o_rdata                    = rdata_ff;
  assign o_sram_addr                = addr_ff;
  assign o_chip_select_active_low   = sel_n_ff;   // R08
  assign o_chip_select_active_high  = sel_ff;
  assign o_out_drive_en_n           = oe_n_ff;
  assign o_write_strobe_n           = we_n_ff;   // R07
  assign o_low_byte_lane_enable_n   = lane_n_ff[0];
  assign o_upper_byte_lane_enable_n = lane_n_ff[1];
  assign o_dq                       = wdata_ff;
  assign o_dq_oe                    = dq_oe_ff;
endmodule : sram_ctl

// file: sim/sram_ctl_chk.sv
/* Pin-level checker for the static memory controller.
   Assumes a bind to sram_ctl and one clock domain. */
`timescale 1ns/10ps
module sram_ctl_chk (
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  input wire logic        o_rvalid,
  input wire logic [19:0] o_sram_addr,
  input wire logic        o_chip_select_active_low,
  input wire logic        o_chip_select_active_high,
  input wire logic        o_out_drive_en_n,
  input wire logic        o_write_strobe_n,
  input wire logic        o_low_byte_lane_enable_n,
  input wire logic        o_upper_byte_lane_enable_n,
  input wire logic        o_dq_oe
);
  int  settle_ff;
  wire sel = !o_chip_select_active_low && o_chip_select_active_high;
  wire lane = !(o_low_byte_lane_enable_n && o_upper_byte_lane_enable_n);
  // Saturating count of cycles since reset release
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) settle_ff <= 0;
    else if (settle_ff < sram_ctl_pkg::POWER_SETTLE_CYC) settle_ff <= settle_ff + 1;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // Strobe up while still selected, then deselect
  sequence strobe_end;
    o_write_strobe_n && sel ##1 !sel;
  endsequence
  a_power_wait: assert property (settle_ff < sram_ctl_pkg::POWER_SETTLE_CYC |-> !sel)
    else $error("select before settle");
  a_write_open: assert property ($fell(o_write_strobe_n) |-> sel && lane)
    else $error("write opened unselected");
  a_write_close: assert property ($rose(o_write_strobe_n) |-> strobe_end)
    else $error("write close order");
  a_pulse_width: assert property ($fell(o_write_strobe_n) |-> o_dq_oe ##1 o_write_strobe_n && o_dq_oe)
    else $error("write pulse length");
  a_read_mode: assert property (!o_out_drive_en_n |-> o_write_strobe_n)
    else $error("strobe low in read");
  a_addr_hold: assert property (sel && $past(sel) |-> $stable(o_sram_addr))
    else $error("address moved while selected");
  a_no_fight: assert property (!o_out_drive_en_n |-> !o_dq_oe)
    else $error("bus contention");
  a_rvalid_pulse: assert property (o_rvalid |=> !o_rvalid)
    else $error("rvalid longer than one cycle");
endmodule : sram_ctl_chk
bind sram_ctl sram_ctl_chk u_chk (.i_mclk, .i_rst_n, .o_rvalid, .o_sram_addr, .o_chip_select_active_low,
  .o_chip_select_active_high, .o_out_drive_en_n, .o_write_strobe_n, .o_low_byte_lane_enable_n,
  .o_upper_byte_lane_enable_n, .o_dq_oe);

// file: sim/sram_dev_model.sv
/* Behavioural 1M x 16 static memory and the shared data wire.
   Assumes level pins from the controller; no clock. */
`timescale 1ns/10ps
module sram_dev_model (
  input  wire logic [19:0] i_addr,
  input  wire logic        i_cs_n,
  input  wire logic        i_cs,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic        i_lb_n,
  input  wire logic        i_ub_n,
  input  wire logic [15:0] i_ctl_dq,
  input  wire logic        i_ctl_oe,
  output logic      [15:0] o_bus
);
  logic [15:0] mem [0:1048575];
  logic [19:0] wa;
  logic [15:0] wd;
  logic [1:0]  wl_n;
  logic [15:0] rv;
  bit          armed;
  wire         sel   = !i_cs_n && i_cs;
  wire         wr_on = sel && !i_we_n;
  wire         rd    = sel && !i_oe_n && i_we_n;
  wire   [1:0] drv   = {2{rd}} & ~{i_ub_n, i_lb_n};
  // Unwritten words read as the inverse of their low address bits
  initial begin
    for (int k = 0; k < 1048576; k++) mem[k] = ~k[15:0];
  end
  // Hold what the write overlap carries; store it when the overlap ends
  always @(i_addr or wr_on or i_lb_n or i_ub_n or i_ctl_dq) begin
    if (wr_on && !(i_lb_n && i_ub_n)) begin
      wa    = i_addr;
      wd    = i_ctl_dq;
      wl_n  = {i_ub_n, i_lb_n};
      armed = 1'b1;
    end else if (armed) begin
      if (!wl_n[0]) mem[wa][7:0] = wd[7:0];
      if (!wl_n[1]) mem[wa][15:8] = wd[15:8];
      armed = 1'b0;
    end
  end
  // Floating lanes show the inverse of the stored byte
  always @(i_addr or i_ctl_oe or i_ctl_dq or drv or armed) begin
    rv = mem[i_addr];
    o_bus = i_ctl_oe ? i_ctl_dq : ~rv;
    if (drv[0]) o_bus[7:0] = rv[7:0];
    if (drv[1]) o_bus[15:8] = rv[15:8];
  end
endmodule : sram_dev_model

// file: sim/testbench.sv
/* Self-checking bench for the static memory controller.
   Assumes the model resolves the data wire from o_dq_oe. */
`timescale 1ns/10ps
module testbench;
  logic        i_mclk, i_rst_n, i_req, i_write, o_ready, o_rvalid, o_dq_oe, o_out_drive_en_n, o_write_strobe_n;
  logic        o_chip_select_active_low, o_chip_select_active_high, o_low_byte_lane_enable_n;
  logic        o_upper_byte_lane_enable_n;
  logic [19:0] i_addr, o_sram_addr;
  logic [15:0] i_wdata, o_rdata, o_dq, i_dq, q;
  logic [1:0]  i_lane_en;
  int          bad_count, samples_checked, n;
  sram_ctl DUT (.i_mclk, .i_rst_n, .i_req, .i_write, .i_addr, .i_wdata, .i_lane_en, .o_ready, .o_rvalid,
    .o_rdata, .o_sram_addr, .o_chip_select_active_low, .o_chip_select_active_high, .o_out_drive_en_n,
    .o_write_strobe_n, .o_low_byte_lane_enable_n, .o_upper_byte_lane_enable_n, .o_dq, .o_dq_oe, .i_dq);
  sram_dev_model u_mem (.i_addr(o_sram_addr), .i_cs_n(o_chip_select_active_low),
    .i_cs(o_chip_select_active_high), .i_oe_n(o_out_drive_en_n), .i_we_n(o_write_strobe_n),
    .i_lb_n(o_low_byte_lane_enable_n), .i_ub_n(o_upper_byte_lane_enable_n), .i_ctl_dq(o_dq),
    .i_ctl_oe(o_dq_oe), .o_bus(i_dq));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One access; waits for ready, returns read data
  task automatic acc(input logic w, input logic [19:0] a, input logic [15:0] d, input logic [1:0] l);
    n = 0;
    while (o_ready !== 1'b1 && n < 100) begin @(posedge i_mclk); #1 n++; end
    if (n >= 100) begin
      bad_count++;
      $display("ERROR %0t ready never came", $time);
    end
    {i_req, i_write, i_addr, i_wdata, i_lane_en} = {1'b1, w, a, d, l};
    @(posedge i_mclk);
    #1 i_req = 1'b0;
    n = 0;
    if (!w && l != 2'b00) begin
      while (o_rvalid !== 1'b1 && n < 10) begin @(posedge i_mclk); #1 n++; end
      if (n >= 10) begin
        bad_count++;
        $display("ERROR %0t read data never came", $time);
      end
      q = o_rdata;
    end
  endtask : acc
  task automatic t_power();
    n = 0;
    while (o_ready !== 1'b1 && n < sram_ctl_pkg::POWER_SETTLE_CYC + 100) begin @(posedge i_mclk); #1 n++; end
    chk({14'h0, o_ready, n >= sram_ctl_pkg::POWER_SETTLE_CYC}, 16'h3);
  endtask : t_power
  task automatic t_lanes();
    acc(1'b1, 20'h00a5a, 16'h1234, 2'h3);
    acc(1'b1, 20'h00a5a, 16'h99ee, 2'h1);
    acc(1'b1, 20'h00a5a, 16'h5577, 2'h2);
    acc(1'b0, 20'h00a5a, 16'h0, 2'h3);
    chk(q, 16'h55ee);
    acc(1'b0, 20'h00a5a, 16'h0, 2'h1);
    chk(q, 16'h00ee);
    acc(1'b0, 20'h00a5a, 16'h0, 2'h2);
    chk(q, 16'h5500);
  endtask : t_lanes
  task automatic t_refuse();
    acc(1'b1, 20'h00a5a, 16'hffff, 2'h0);
    chk({15'h0, o_ready}, 16'h1);
    acc(1'b1, 20'hfffff, 16'hc3a5, 2'h3);
    acc(1'b0, 20'h00a5a, 16'h0, 2'h3);
    chk(q, 16'h55ee);
    acc(1'b0, 20'hfffff, 16'h0, 2'h3);
    chk(q, 16'hc3a5);
  endtask : t_refuse
  task automatic wrap_up();
    if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // Clock
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  // Watchdog
  initial begin
    repeat (sram_ctl_pkg::POWER_SETTLE_CYC + 2000) @(posedge i_mclk);
    bad_count++;
    wrap_up();
  end
  // Main sequence
  initial begin
    {i_rst_n, i_req, i_write, i_addr, i_wdata, i_lane_en, q} = '0;
    repeat (12) @(posedge i_mclk);
    #1 i_rst_n = 1'b1;
    t_power();
    t_lanes();
    t_refuse();
    wrap_up();
  end
endmodule : testbench
